// *** inc/xmif_pkg.sv ***
/*
 * xmif_pkg: constants and carrier types for the external data memory interface.
 * assumes one system clock at 250 MHz and an 8-bit special register port on the cpu side.
 */
`default_nettype none

package xmif_pkg;

  // ----------------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] XMIF_CFG_ADDR = 8'h85;
  localparam logic [7:0] XMIF_PAGE_ADDR = 8'haa;
  localparam logic [7:0] XMIF_CFG_RESET = 8'h03;
  localparam logic [7:0] XMIF_PAGE_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------------
  localparam int XMIF_FIFO_EN_BIT = 6;
  localparam int XMIF_MUX_BIT = 4;
  localparam int XMIF_MODE_LSB = 2;
  localparam int XMIF_ALE_LSB = 0;
  localparam logic [7:0] XMIF_CFG_RD_MASK = 8'h5f;

  // ----------------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------------
  localparam logic [15:0] XMIF_FIFO_BASE = 16'h0400;
  localparam logic [15:0] XMIF_FIFO_LAST = 16'h07ff;
  localparam logic [15:0] XMIF_ONCHIP_LIMIT = 16'h2000;
  localparam int XMIF_ONCHIP_AW = 12;
  localparam int XMIF_FIFO_AW = 10;

  // ----------------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------------
  localparam logic [1:0] XMIF_STROBE_CYC = 2'h1;
  localparam logic [1:0] XMIF_FIFO_WAIT_CYC = 2'h3;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    XMIF_MODE_INT = 2'h0,
    XMIF_MODE_SPLIT = 2'h1,
    XMIF_MODE_BANK = 2'h2,
    XMIF_MODE_EXT = 2'h3
  } xmif_mode_t;

  typedef struct packed {
    logic fifo_window_enable;
    logic bus_multiplex_select;
    xmif_mode_t memory_mode_select;
    logic [1:0] latch_pulse_width_select;
  } xmif_cfg_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic short_addr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xmif_cpu_req_t;

  typedef struct packed {
    logic [15:0] addr_o;
    logic [15:0] addr_oe;
    logic [7:0] data_o;
    logic [7:0] data_oe;
    logic ale;
    logic rd_b;
    logic wr_b;
    logic own;
  } xmif_pins_t;

endpackage : xmif_pkg

`default_nettype wire

// *** rtl/xmif_core.sv ***
/*
 * xmif_core: address decode and bus sequencing for external move instructions.
 * assumes the cpu holds its request until ack, port muxing outside honours
 * pins.own, and fifo ram answers through a req/ack handshake from the usb domain.
 */
`default_nettype none


module xmif_core (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // special register port
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // cpu external move request
  input wire xmif_pkg::xmif_cpu_req_t cpu_req_i,
  output logic cpu_ack_o,
  output logic [7:0] cpu_rdata_o,
  // on-chip external_data_ram
  output logic external_data_ram_we_o,
  output logic [xmif_pkg::XMIF_ONCHIP_AW-1:0] external_data_ram_addr_o,
  output logic [7:0] external_data_ram_wdata_o,
  input wire logic [7:0] external_data_ram_rdata_i,
  // usb fifo ram, handshake into the usb domain
  output logic fifo_req_o,
  output logic fifo_we_o,
  output logic [xmif_pkg::XMIF_FIFO_AW-1:0] fifo_addr_o,
  output logic [7:0] fifo_wdata_o,
  input wire logic fifo_ack_i,
  input wire logic [7:0] fifo_rdata_i,
  // external bus pins
  output xmif_pkg::xmif_pins_t pins_o,
  input wire logic [7:0] data_pins_i
);
  import xmif_pkg::*;

  // every assertion below runs on the system clock and rests in reset
  default clocking xmif_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ONCHIP, ST_FIFO, ST_ALE_HI, ST_ALE_LO, ST_STROBE, ST_DONE
  } xmif_state_t;

  typedef struct packed {
    xmif_state_t st;
    xmif_cfg_t cfg;
    logic [7:0] page;
    xmif_cfg_t acc_cfg;
    logic acc_wr;
    logic drive_hi;
    logic [15:0] acc_addr;
    logic [7:0] acc_wdata;
    logic [2:0] cnt;
    logic fifo_req;
    logic sync1;
    logic sync2;
    logic sync_prev;
    logic [7:0] rdata;
    logic ack;
  } xmif_s_t;

  xmif_s_t s_reg;
  xmif_s_t s_next;
  logic [15:0] eff_addr;
  logic in_fifo;
  logic onchip;
  logic fifo_done;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------

  // effective address from page byte or data pointer
  always_comb begin
    eff_addr = cpu_req_i.addr;
    if (cpu_req_i.short_addr) begin
      eff_addr = {s_reg.page, cpu_req_i.addr[7:0]};
    end
    in_fifo = s_reg.cfg.fifo_window_enable && eff_addr >= XMIF_FIFO_BASE
      && eff_addr <= XMIF_FIFO_LAST;
    unique case (s_reg.cfg.memory_mode_select)
      XMIF_MODE_INT: onchip = 1'b1;
      XMIF_MODE_SPLIT, XMIF_MODE_BANK: onchip = eff_addr < XMIF_ONCHIP_LIMIT;
      XMIF_MODE_EXT: onchip = 1'b0;
    endcase
  end

  // fifo completion seen as a toggle edge after two flops
  assign fifo_done = s_reg.sync2 != s_reg.sync_prev;

  // ----------------------------------------------------------------------
  // sequencer and registers
  // ----------------------------------------------------------------------

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.sync1 = fifo_ack_i;
    s_next.sync2 = s_reg.sync1;
    s_next.sync_prev = s_reg.sync2;
    if (sfr_wr_i && sfr_addr_i == XMIF_CFG_ADDR) begin
      s_next.cfg = xmif_cfg_t'({sfr_wdata_i[XMIF_FIFO_EN_BIT], sfr_wdata_i[XMIF_MUX_BIT],
        sfr_wdata_i[XMIF_MODE_LSB+1:XMIF_MODE_LSB], sfr_wdata_i[XMIF_ALE_LSB+1:XMIF_ALE_LSB]});
    end
    if (sfr_wr_i && sfr_addr_i == XMIF_PAGE_ADDR) begin
      s_next.page = sfr_wdata_i;
    end
    unique case (s_reg.st)
      ST_IDLE: begin
        if (cpu_req_i.req) begin
          s_next.acc_cfg = s_reg.cfg;
          s_next.acc_wr = cpu_req_i.wr;
          s_next.acc_addr = eff_addr;
          s_next.acc_wdata = cpu_req_i.wdata;
          s_next.drive_hi = !(cpu_req_i.short_addr
            && s_reg.cfg.memory_mode_select != XMIF_MODE_BANK);
          s_next.cnt = 3'h0;
          if (in_fifo) begin
            s_next.st = ST_FIFO;
            s_next.fifo_req = !s_reg.fifo_req;
          end else if (onchip) begin
            s_next.st = ST_ONCHIP;
          end else if (s_reg.cfg.bus_multiplex_select) begin
            s_next.st = ST_STROBE;
          end else begin
            s_next.st = ST_ALE_HI;
          end
        end
      end
      ST_ONCHIP: begin
        s_next.rdata = external_data_ram_rdata_i;
        s_next.ack = 1'b1;
        s_next.st = ST_DONE;
      end
      ST_FIFO: begin
        if (fifo_done) begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
        if (s_reg.cnt != 3'h0) begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
        if (s_reg.cnt[1:0] == XMIF_FIFO_WAIT_CYC) begin
          s_next.rdata = fifo_rdata_i;
          s_next.ack = 1'b1;
          s_next.st = ST_DONE;
        end
      end
      ST_ALE_HI: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt[1:0] == s_reg.acc_cfg.latch_pulse_width_select) begin
          s_next.cnt = 3'h0;
          s_next.st = ST_ALE_LO;
        end
      end
      ST_ALE_LO: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt[1:0] == s_reg.acc_cfg.latch_pulse_width_select) begin
          s_next.cnt = 3'h0;
          s_next.st = ST_STROBE;
        end
      end
      ST_STROBE: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt[1:0] == XMIF_STROBE_CYC - 2'h1) begin
          s_next.rdata = data_pins_i;
          s_next.ack = 1'b1;
          s_next.st = ST_DONE;
        end
      end
      ST_DONE: begin
        s_next.st = ST_IDLE; // request drops during this cycle
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
      s_reg.cfg <= xmif_cfg_t'({XMIF_CFG_RESET[XMIF_FIFO_EN_BIT], XMIF_CFG_RESET[XMIF_MUX_BIT],
        XMIF_CFG_RESET[XMIF_MODE_LSB+1:XMIF_MODE_LSB], XMIF_CFG_RESET[XMIF_ALE_LSB+1:XMIF_ALE_LSB]});
      s_reg.page <= XMIF_PAGE_RESET;
      s_reg.st <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------

  // register readback
  always_comb begin
    sfr_rdata_o = 8'h00;
    if (sfr_addr_i == XMIF_CFG_ADDR) begin
      sfr_rdata_o = {1'b0, s_reg.cfg.fifo_window_enable, 1'b0, s_reg.cfg.bus_multiplex_select,
        s_reg.cfg.memory_mode_select, s_reg.cfg.latch_pulse_width_select} & XMIF_CFG_RD_MASK;
    end else if (sfr_addr_i == XMIF_PAGE_ADDR) begin
      sfr_rdata_o = s_reg.page;
    end
  end

  assign cpu_ack_o = s_reg.ack;
  assign cpu_rdata_o = s_reg.rdata;
  assign external_data_ram_we_o = s_reg.st == ST_ONCHIP && s_reg.acc_wr;
  assign external_data_ram_addr_o = s_reg.acc_addr[XMIF_ONCHIP_AW-1:0];
  assign external_data_ram_wdata_o = s_reg.acc_wdata;
  assign fifo_req_o = s_reg.fifo_req;
  assign fifo_we_o = s_reg.acc_wr;
  assign fifo_addr_o = s_reg.acc_addr[XMIF_FIFO_AW-1:0];
  assign fifo_wdata_o = s_reg.acc_wdata;

  // pin drive; output mode registers stay outside this block
  always_comb begin
    logic busy;
    logic mux;
    busy = s_reg.st == ST_ALE_HI || s_reg.st == ST_ALE_LO || s_reg.st == ST_STROBE;
    mux = !s_reg.acc_cfg.bus_multiplex_select;
    pins_o.own = busy;
    pins_o.ale = s_reg.st == ST_ALE_HI;
    pins_o.rd_b = !(s_reg.st == ST_STROBE && !s_reg.acc_wr);
    pins_o.wr_b = !(s_reg.st == ST_STROBE && s_reg.acc_wr);
    pins_o.addr_o = s_reg.acc_addr;
    pins_o.addr_oe = {{8{busy && s_reg.drive_hi}}, {8{busy && !mux}}};
    pins_o.data_o = (mux && s_reg.st == ST_ALE_HI) ? s_reg.acc_addr[7:0] : s_reg.acc_wdata;
    pins_o.data_oe = {8{busy && (s_reg.acc_wr || (mux && s_reg.st == ST_ALE_HI))}};
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------

  // one-cycle latch pulse high, then one cycle low
  sequence ale_phase_s;
    pins_o.ale ##1 !pins_o.ale;
  endsequence

  // two- and four-cycle latch pulses, low for as long as high
  sequence ale_wide2_s;
    pins_o.ale [*2] ##1 !pins_o.ale [*2];
  endsequence

  sequence ale_wide4_s;
    pins_o.ale [*4] ##1 !pins_o.ale [*4];
  endsequence

  // a read or write strobe on the pins
  sequence strobe_s;
    !pins_o.rd_b || !pins_o.wr_b;
  endsequence

  // off-chip move taken from idle, shared or separate pins
  sequence mux_take_s;
    s_reg.st == ST_IDLE && cpu_req_i.req && !in_fifo && !onchip
      && !s_reg.cfg.bus_multiplex_select;
  endsequence

  sequence nonmux_take_s;
    s_reg.st == ST_IDLE && cpu_req_i.req && !in_fifo && !onchip
      && s_reg.cfg.bus_multiplex_select;
  endsequence

  chk_pins_only_busy: assert property (
    pins_o.own |-> (s_reg.st != ST_IDLE && s_reg.st != ST_ONCHIP))
    else $error("pins owned outside an off-chip access");
  chk_read_drivers_off: assert property (
    !pins_o.rd_b |-> pins_o.data_oe == 8'h00)
    else $error("data driven during read strobe");
  chk_fifo_window_map: assert property (
    (s_reg.st == ST_IDLE && cpu_req_i.req && in_fifo) |=> s_reg.st == ST_FIFO)
    else $error("fifo window access not routed to fifo");
  chk_fifo_slower: assert property (
    (s_reg.st == ST_IDLE && cpu_req_i.req && in_fifo) |=> !cpu_ack_o [*4])
    else $error("fifo access acknowledged too early");
  chk_fifo_toggle: assert property (
    (s_reg.st == ST_IDLE && cpu_req_i.req && in_fifo) |=> fifo_req_o != $past(fifo_req_o))
    else $error("fifo request did not toggle");
  chk_fifo_no_pins: assert property (
    s_reg.st == ST_FIFO |-> !external_data_ram_we_o && !pins_o.own)
    else $error("fifo access leaked to external_data_ram or pins");
  chk_internal_mode: assert property (
    (s_reg.st == ST_IDLE && cpu_req_i.req && !in_fifo
     && s_reg.cfg.memory_mode_select == XMIF_MODE_INT) |=> s_reg.st == ST_ONCHIP)
    else $error("internal mode went off-chip");
  chk_external_mode: assert property (
    (s_reg.st == ST_IDLE && cpu_req_i.req && !in_fifo
     && s_reg.cfg.memory_mode_select == XMIF_MODE_EXT) |=> pins_o.own)
    else $error("external mode stayed on-chip");
  chk_short_page: assert property (
    (s_reg.st == ST_IDLE && cpu_req_i.req && cpu_req_i.short_addr)
    |=> s_reg.acc_addr[15:8] == $past(s_reg.page))
    else $error("short move high byte not from page select");
  chk_long_pointer: assert property (
    (s_reg.st == ST_IDLE && cpu_req_i.req && !cpu_req_i.short_addr)
    |=> s_reg.acc_addr == $past(cpu_req_i.addr))
    else $error("long move address not from data pointer");
  chk_mux_addr_phase: assert property (
    mux_take_s |=> pins_o.ale && pins_o.data_oe == 8'hff
      && pins_o.data_o == $past(eff_addr[7:0]))
    else $error("shared pins lack the low address under the latch strobe");
  chk_nonmux_pins: assert property (
    nonmux_take_s |=> pins_o.own && !pins_o.ale && pins_o.addr_oe[7:0] == 8'hff)
    else $error("separate-pin move lacks its own address lines");
  chk_mux_lo_shared: assert property (
    pins_o.own && !s_reg.acc_cfg.bus_multiplex_select |-> pins_o.addr_oe[7:0] == 8'h00)
    else $error("low address lines driven in shared-pin mode");
  chk_ale_before_strobe: assert property (
    ($rose(pins_o.ale) && s_reg.acc_cfg.latch_pulse_width_select == 2'h0)
    |-> ale_phase_s ##1 strobe_s)
    else $error("latch strobe sequence wrong");
  chk_ale_width_two: assert property (
    ($rose(pins_o.ale) && s_reg.acc_cfg.latch_pulse_width_select == 2'h1)
    |-> ale_wide2_s ##1 strobe_s)
    else $error("two-cycle latch strobe wrong");
  chk_ale_width_four: assert property (
    ($rose(pins_o.ale) && s_reg.acc_cfg.latch_pulse_width_select == 2'h3)
    |-> ale_wide4_s ##1 strobe_s)
    else $error("four-cycle latch strobe wrong");
  chk_split_hi_float: assert property (
    (pins_o.own && !s_reg.drive_hi) |-> pins_o.addr_oe[15:8] == 8'h00)
    else $error("high address driven in no-bank mode");
  chk_bank_hi_driven: assert property (
    (pins_o.own && s_reg.acc_cfg.memory_mode_select == XMIF_MODE_BANK)
    |-> pins_o.addr_oe[15:8] == 8'hff)
    else $error("high address not driven in bank mode");
  chk_cfg_held: assert property (
    pins_o.own && $past(pins_o.own) |-> $stable(s_reg.acc_cfg))
    else $error("access config changed mid access");

endmodule : xmif_core

`default_nettype wire

// *** sim/xmif_sram_model.sv ***
/*
 * xmif_sram_model: behavioural off-chip sram seen through the bus pins.
 * assumes the pins struct of xmif_pkg and address port latches parked high.
 */
`default_nettype none

module xmif_sram_model (
  // clock
  input wire logic sys_clk_i,
  // bus pins from the interface
  input wire xmif_pkg::xmif_pins_t pins_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import xmif_pkg::*;

  logic [7:0] mem [0:65535];
  logic [7:0] low_reg = 8'h00;
  logic [7:0] last_reg = 8'h00;
  logic ale_seen_reg = 1'b0;
  logic [15:0] addr;

  // undriven high lines read the parked latch level
  assign addr = {(pins_i.addr_oe[15:8] == 8'hff) ? pins_i.addr_o[15:8] : 8'hff,
                 ale_seen_reg ? low_reg : pins_i.addr_o[7:0]};
  // memory drives only under the read strobe, else a pattern that keeps changing
  assign data_o = (pins_i.own && !pins_i.rd_b) ? mem[addr] : ~last_reg;

  // external latch follows while ale is high and holds after it falls
  always @(posedge sys_clk_i) begin
    last_reg <= data_o;
    if (pins_i.ale) begin
      low_reg <= pins_i.data_o;
      ale_seen_reg <= 1'b1;
    end else if (!pins_i.own) begin
      ale_seen_reg <= 1'b0;
    end
    if (pins_i.own && !pins_i.wr_b) begin
      mem[addr] <= pins_i.data_o;
    end
  end
endmodule : xmif_sram_model

`default_nettype wire

// *** sim/external_data_memory_interface_tb.sv ***
/*
 * bench: register, corner and random external moves through xmif_core.
 * assumes xmif_pkg, xmif_sram_model and a 4 ns system clock.
 */
`default_nettype none

module external_data_memory_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import xmif_pkg::*;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] fifo_rdata = 8'h00;
  logic [7:0] sfr_rdata, rdata, external_data_ram_wdata, external_data_ram_rdata, fifo_wdata, data_pins;
  logic ack, external_data_ram_we, fifo_req, fifo_we;
  logic fifo_ack = 1'b0;
  logic last_req = 1'b0;
  logic [11:0] external_data_ram_addr;
  logic [9:0] fifo_addr;
  xmif_cpu_req_t req = '0;
  xmif_pins_t pins;
  logic [7:0] external_data_ram [0:4095];
  logic [7:0] fifo [0:1023];
  logic [7:0] cfg = 8'h03;
  logic [7:0] page = 8'h00;
  integer seed = 32'hce0862f1;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int fdly = 0;
  int ale_n = 0;
  int cur_ale = 0;

  always #2 clk = ~clk;

  xmif_core i_dut (
    .sys_clk_i(clk), .rst_b_i(rst_b), .sfr_wr_i(sfr_wr), .sfr_addr_i(sfr_addr),
    .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata), .cpu_req_i(req), .cpu_ack_o(ack),
    .cpu_rdata_o(rdata), .external_data_ram_we_o(external_data_ram_we), .external_data_ram_addr_o(external_data_ram_addr),
    .external_data_ram_wdata_o(external_data_ram_wdata), .external_data_ram_rdata_i(external_data_ram_rdata), .fifo_req_o(fifo_req),
    .fifo_we_o(fifo_we), .fifo_addr_o(fifo_addr), .fifo_wdata_o(fifo_wdata),
    .fifo_ack_i(fifo_ack), .fifo_rdata_i(fifo_rdata), .pins_o(pins), .data_pins_i(data_pins)
  );

  // strobe pins reach the memory directly, as if skipped in the crossbar
  xmif_sram_model i_mem (.sys_clk_i(clk), .pins_i(pins), .data_o(data_pins));

  // on-chip ram: combinational read, write on the clock
  assign external_data_ram_rdata = external_data_ram[external_data_ram_addr];
  always @(posedge clk) if (external_data_ram_we) external_data_ram[external_data_ram_addr] <= external_data_ram_wdata;

  // fifo ram answers each request toggle after one to four clocks
  always @(posedge clk) begin
    if (fdly == 1) begin
      if (fifo_we) fifo[fifo_addr] <= fifo_wdata;
      fifo_rdata <= fifo[fifo_addr];
      fifo_ack <= ~fifo_ack;
    end
    if (fdly > 0) fdly <= fdly - 1;
    else if (rst_b && fifo_req !== last_req) begin
      last_req <= fifo_req;
      fdly <= 1 + ($random(seed) & 3);
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic ok, input string m);
    chk_val({31'h0, ok}, 32'h1, m);
  endtask : chk_flag

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // pin watch at the falling edge, where outputs have settled
  always @(negedge clk) if (rst_b) begin
    if (!pins.rd_b) chk_flag(pins.data_oe === 8'h00, "read drives data");
    if (!pins.wr_b) chk_flag(pins.data_oe === 8'hff, "write data off");
    if (!pins.own) chk_flag({pins.addr_oe, pins.data_oe, pins.ale, pins.rd_b, pins.wr_b} === 27'h3,
                            "pins held outside access");
    if (pins.ale) ale_n <= ale_n + 1;
    else if (ale_n > 0) begin
      chk_val(ale_n, cur_ale + 1, "ale width");
      ale_n <= 0;
    end
  end

  // cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  // expected target: kind (0 on-chip, 1 fifo, 2 off-chip) and address
  function automatic logic [17:0] resolve(input logic s, input logic [15:0] a);
    logic [15:0] e;
    e = s ? {page, a[7:0]} : a;
    if (cfg[6] && e >= 16'h0400 && e <= 16'h07ff) return {2'h1, 6'h00, e[9:0]};
    if (cfg[3:2] == 2'h0 || (cfg[3:2] != 2'h3 && e < 16'h2000)) return {2'h0, 4'h0, e[11:0]};
    if (s && cfg[3:2] != 2'h2) return {2'h2, 8'hff, a[7:0]};
    return {2'h2, e};
  endfunction : resolve

  function automatic logic [7:0] peek(input logic [17:0] k);
    if (k[17:16] == 2'h0) return external_data_ram[k[11:0]];
    if (k[17:16] == 2'h1) return fifo[k[9:0]];
    return i_mem.mem[k[15:0]];
  endfunction : peek

  task automatic poke(input logic [17:0] k, input logic [7:0] d);
    if (k[17:16] == 2'h0) external_data_ram[k[11:0]] = d;
    else if (k[17:16] == 2'h1) fifo[k[9:0]] = d;
    else i_mem.mem[k[15:0]] = d;
  endtask : poke

  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    if (a == XMIF_CFG_ADDR) cfg = d;
    if (a == XMIF_PAGE_ADDR) page = d;
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : sfr_w

  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    @(negedge clk);
    chk_val(sfr_rdata, exp, "register read");
  endtask : sfr_chk

  // one external move; bump rewrites the config while it runs
  task automatic xfer(input logic wr, input logic s, input logic [15:0] a, input logic [7:0] d,
                      input logic bump);
    logic [17:0] k;
    int n;
    int lat;
    k = resolve(s, a);
    lat = (k[17:16] == 2'h2 && !cfg[4]) ? 4 + 2 * cfg[1:0] : 2;
    // fifo: toggle seen, one to four model clocks, two flops, then the fixed wait
    if (k[17:16] == 2'h1) lat = 6 + XMIF_FIFO_WAIT_CYC;
    cur_ale = cfg[4] ? -1 : cfg[1:0];
    if (!wr) poke(k, d);
    @(posedge clk);
    req <= '{1'b1, wr, s, a, d};
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
      if (bump && n == 1) begin
        sfr_wr <= 1'b1;
        sfr_addr <= XMIF_CFG_ADDR;
        sfr_wdata <= cfg ^ 8'h13;
      end
      if (n == 2) sfr_wr <= 1'b0;
    end while (ack !== 1'b1 && n < 300);
    if (k[17:16] == 2'h1) chk_flag(n >= lat && n <= lat + 3, "fifo stall");
    else chk_val(n, lat, "ack latency");
    @(posedge clk);
    req.req <= 1'b0;
    if (wr) chk_val(peek(k), d, "stored byte");
    else chk_val(rdata, d, "read byte");
    if (bump) sfr_w(XMIF_CFG_ADDR, cfg);
  endtask : xfer

  // main sequence: registers, corner map cases, then random moves
  initial begin : main
    logic [31:0] r;
    logic [15:0] a;
    logic [31:0] corner [0:7];
    corner = '{32'h0f00_0000, 32'h5404_03ff, 32'h5407_0400, 32'h441f_07ff,
               32'h1820_2000, 32'h0620_ffff, 32'h0055_1234, 32'h4c55_0500};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    sfr_chk(XMIF_CFG_ADDR, 8'h03);
    sfr_chk(XMIF_PAGE_ADDR, 8'h00);
    sfr_chk(8'h86, 8'h00);
    sfr_w(XMIF_CFG_ADDR, 8'hff);
    sfr_chk(XMIF_CFG_ADDR, 8'h5f);
    sfr_w(XMIF_PAGE_ADDR, 8'ha5);
    sfr_chk(XMIF_PAGE_ADDR, 8'ha5);
    $display("test registers done");
    foreach (corner[i]) begin
      sfr_w(XMIF_CFG_ADDR, corner[i][31:24]);
      sfr_w(XMIF_PAGE_ADDR, corner[i][23:16]);
      for (int w = 0; w < 4; w++) begin
        r = $random(seed);
        xfer(w[0], w[1], corner[i][15:0], r[7:0], i == 0);
      end
    end
    $display("test corners done");
    repeat (60) begin
      r = $random(seed);
      sfr_w(XMIF_CFG_ADDR, r[7:0]);
      // split mode without bank select gets a page above on-chip space
      sfr_w(XMIF_PAGE_ADDR, r[15:8] | {2'h0, r[3:2] == 2'h1, 5'h00});
      repeat (6) begin
        r = $random(seed);
        a = r[31] ? {6'h01, r[9:0]} : r[15:0];
        xfer(r[30], r[29], a, r[23:16], r[28:26] == 3'h0);
      end
    end
    $display("test random done");
    stop_test();
  end
endmodule : external_data_memory_interface_tb

`default_nettype wire
